// >>> hw/crsx_pkg.sv
/*
  crsx_pkg: shared constants for the rotate/subtract/xor/sleep execution block.
  Assumes nothing of its surroundings; used with explicit package scope only.
*/
package crsx_pkg;
  // data width of the accumulator and file registers
  localparam int unsigned DATA_W = 8;
  // register byte offsets (word aligned, Avalon-MM byte addresses)
  localparam logic [4:0] OFF_ACC = 5'h00;
  localparam logic [4:0] OFF_STATUS = 5'h04;
  localparam logic [4:0] OFF_CMD = 5'h08;
  localparam logic [4:0] OFF_FILE_DATA = 5'h0C;
  localparam logic [4:0] OFF_RESULT = 5'h10;
  // command register fields
  localparam int unsigned CMD_OP_LSB = 0;
  localparam int unsigned CMD_DEST_BIT = 3;
  localparam int unsigned CMD_ARG_LSB = 8;
  // status register fields
  localparam int unsigned ST_CARRY = 0;
  localparam int unsigned ST_NIBBLE = 1;
  localparam int unsigned ST_NULL = 2;
  localparam int unsigned ST_PDOWN = 3;
  localparam int unsigned ST_WDOG = 4;
  localparam int unsigned ST_SLEEP = 5;
  localparam int unsigned ST_FWRITE = 6;
  // reset values
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [7:0] STATUS_RST = 8'h00;
  // operation codes
  typedef enum logic [2:0] {
    OP_ROT = 3'h1,
    OP_SUB = 3'h2,
    OP_SUBB = 3'h3,
    OP_XORL = 3'h4,
    OP_XORF = 3'h5,
    OP_SLEEP = 3'h6
  } crsx_op_type;
endpackage

// >>> hw/crsx_alu.sv
/*
  crsx_alu: combinational arithmetic for rotate, subtract and exclusive-or.
  Assumes operands are stable for one cycle; the caller registers results.
*/
`timescale 1ns/1ps
`default_nettype none
module crsx_alu #(
  parameter int unsigned W = 8
) (
  // operation select
  input wire logic [2:0] op,
  // operands
  input wire logic [W-1:0] acc,
  input wire logic [W-1:0] fil,
  input wire logic [W-1:0] lit,
  input wire logic carry_in,
  // results
  output logic [W-1:0] res,
  output logic carry_out,
  output logic nibble_out,
  output logic null_out
);
  logic [W:0] diff;
  logic [4:0] ndiff;
  logic sub_b;

  // subtraction with not-borrow: no borrow in means carry_in set
  always_comb begin
    sub_b = (op == crsx_pkg::OP_SUBB) ? ~carry_in : 1'b0;
    diff = {1'b0, fil} - {1'b0, acc} - {{W{1'b0}}, sub_b};
    ndiff = {1'b0, fil[3:0]} - {1'b0, acc[3:0]} - {4'h0, sub_b};
  end

  // result mux and flags
  always_comb begin
    res = '0;
    carry_out = carry_in;
    nibble_out = 1'b0;
    unique case (op)
      crsx_pkg::OP_ROT: begin
        res = {carry_in, fil[W-1:1]};
        carry_out = fil[0];
      end
      crsx_pkg::OP_SUB, crsx_pkg::OP_SUBB: begin
        res = diff[W-1:0];
        carry_out = ~diff[W];
        nibble_out = ~ndiff[4];
      end
      crsx_pkg::OP_XORL: res = acc ^ lit;
      crsx_pkg::OP_XORF: res = acc ^ fil;
      default: res = '0;
    endcase
    null_out = (res == '0);
  end
endmodule
`default_nettype wire

// >>> hw/crsx_sync.sv
/*
  crsx_sync: two-flop level synchroniser.
  Assumes the input is a slowly changing level from outside the clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module crsx_sync (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // level in and out
  input wire logic din,
  output logic dout
);
  logic meta_q;

  // first flop feeds only the second
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      meta_q <= 1'b0;
      dout <= 1'b0;
    end else begin
      meta_q <= din;
      dout <= meta_q;
    end
  end
endmodule
`default_nettype wire

// >>> hw/crsx_exec.sv
/*
  crsx_exec: execution unit for rotate-through-carry, subtract, subtract with
  borrow, exclusive-or and sleep, with an Avalon-MM register slave.
  Assumes a 10 MHz clock, async active-low reset, and an external wake level
  from outside the clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
// Function
// - destination bit picks accumulator or file
// - rotate right through carry, one cycle
// - subtract accumulator from file, update flags
// - carry set when no borrow occurred
// - null flag set on zero result
// - subtract with borrow also removes inverted carry
// - xor literal into accumulator, null only
// - xor accumulator with file, null only
// - sleep stops clock until external wake
// - sleep sets power-down, clears watchdog flag
module crsx_exec (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // avalon-mm slave
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // wake source and sleep state
  input wire logic ext_wake,
  output logic cpu_clock_run_q
);
  logic [7:0] acc_q;
  logic [7:0] file_q;
  logic [7:0] result_q;
  logic carry_q;
  logic nibble_q;
  logic null_q;
  logic pdown_q;
  logic wdog_q;
  logic sleep_q;
  logic fwrite_q;
  logic ack_q;
  logic wake_s;
  logic exec_go;
  logic file_op;
  logic [2:0] op;
  logic dest;
  logic [7:0] arg;
  logic [7:0] alu_res;
  logic alu_c;
  logic alu_n;
  logic alu_z;
  logic [7:0] status;

  // wake pin crosses from outside
  crsx_sync u_sync (
    .clock(clock),
    .rstn(rstn),
    .din(ext_wake),
    .dout(wake_s)
  );

  // command fields
  assign op = avs_writedata[crsx_pkg::CMD_OP_LSB +: 3];
  assign dest = avs_writedata[crsx_pkg::CMD_DEST_BIT];
  assign arg = avs_writedata[crsx_pkg::CMD_ARG_LSB +: 8];
  // a command executes on the accepted write to the command register, except while sleep_q is set
  assign exec_go = avs_write && !ack_q && avs_address == crsx_pkg::OFF_CMD
    && avs_byteenable[0] && !sleep_q;
  // these codes honour dest (xor literal always writes the accumulator); no-operation and unused codes leave data alone
  assign file_op = op inside {crsx_pkg::OP_ROT, crsx_pkg::OP_SUB, crsx_pkg::OP_SUBB,
    crsx_pkg::OP_XORF};

  crsx_alu #(.W(crsx_pkg::DATA_W)) u_alu (
    .op(op),
    .acc(acc_q),
    .fil(file_q),
    .lit(arg),
    .carry_in(carry_q),
    .res(alu_res),
    .carry_out(alu_c),
    .nibble_out(alu_n),
    .null_out(alu_z)
  );

  // one wait state on every access, so each answer is registered
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (avs_read || avs_write) && !ack_q;
    end
  end

  // waitrequest high until the acknowledging cycle
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && !ack_q);
    end
  end

  // accumulator: direct write or instruction result
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      acc_q <= crsx_pkg::ACC_RST;
    end else if (exec_go) begin
      if (op == crsx_pkg::OP_XORL) begin
        acc_q <= alu_res;
      end else if (file_op && !dest) begin
        acc_q <= alu_res;
      end
    end else if (avs_write && !ack_q && avs_address == crsx_pkg::OFF_ACC
        && avs_byteenable[0]) begin
      acc_q <= avs_writedata[7:0];
    end
  end

  // file operand: loaded by software, written back when dest is set
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      file_q <= 8'h00;
      fwrite_q <= 1'b0;
    end else if (exec_go) begin
      fwrite_q <= 1'b0;
      if (file_op && dest) begin
        file_q <= alu_res;
        fwrite_q <= 1'b1;
      end
    end else if (avs_write && !ack_q && avs_address == crsx_pkg::OFF_FILE_DATA
        && avs_byteenable[0]) begin
      file_q <= avs_writedata[7:0];
    end
  end

  // last result for inspection
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      result_q <= 8'h00;
    end else if (exec_go && (file_op || op == crsx_pkg::OP_XORL)) begin
      result_q <= alu_res;
    end
  end

  // arithmetic flags per instruction
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      carry_q <= crsx_pkg::STATUS_RST[crsx_pkg::ST_CARRY];
      nibble_q <= crsx_pkg::STATUS_RST[crsx_pkg::ST_NIBBLE];
      null_q <= crsx_pkg::STATUS_RST[crsx_pkg::ST_NULL];
    end else if (exec_go) begin
      unique case (op)
        crsx_pkg::OP_ROT: carry_q <= alu_c;
        crsx_pkg::OP_SUB, crsx_pkg::OP_SUBB: begin
          carry_q <= alu_c;
          nibble_q <= alu_n;
          null_q <= alu_z;
        end
        crsx_pkg::OP_XORL, crsx_pkg::OP_XORF: null_q <= alu_z;
        default: ;
      endcase
    end else if (avs_write && !ack_q && avs_address == crsx_pkg::OFF_STATUS
        && avs_byteenable[0]) begin
      carry_q <= avs_writedata[crsx_pkg::ST_CARRY];
      nibble_q <= avs_writedata[crsx_pkg::ST_NIBBLE];
      null_q <= avs_writedata[crsx_pkg::ST_NULL];
    end
  end

  // sleep state; power-down stays set until reset
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pdown_q <= 1'b0;
      sleep_q <= 1'b0;
      cpu_clock_run_q <= 1'b1;
    end else if (exec_go && op == crsx_pkg::OP_SLEEP) begin
      pdown_q <= 1'b1;
      sleep_q <= 1'b1;
      cpu_clock_run_q <= 1'b0;
    end else if (sleep_q && wake_s) begin
      sleep_q <= 1'b0;
      cpu_clock_run_q <= 1'b1;
    end
  end

  // the watchdog is outside, so software sets its flag in its stead and sleep clears it
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wdog_q <= 1'b0;
    end else if (exec_go && op == crsx_pkg::OP_SLEEP) begin
      wdog_q <= 1'b0;
    end else if (avs_write && !ack_q && avs_address == crsx_pkg::OFF_STATUS
        && avs_byteenable[0]) begin
      wdog_q <= avs_writedata[crsx_pkg::ST_WDOG];
    end
  end

  // status image
  always_comb begin
    status = 8'h00;
    status[crsx_pkg::ST_CARRY] = carry_q;
    status[crsx_pkg::ST_NIBBLE] = nibble_q;
    status[crsx_pkg::ST_NULL] = null_q;
    status[crsx_pkg::ST_PDOWN] = pdown_q;
    status[crsx_pkg::ST_WDOG] = wdog_q;
    status[crsx_pkg::ST_SLEEP] = sleep_q;
    status[crsx_pkg::ST_FWRITE] = fwrite_q;
  end

  // read data registered; unmapped offsets read zero
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      avs_readdata <= 32'h00000000;
    end else if (avs_read && !ack_q) begin
      unique case (avs_address)
        crsx_pkg::OFF_ACC: avs_readdata <= {24'h000000, acc_q};
        crsx_pkg::OFF_STATUS: avs_readdata <= {24'h000000, status};
        crsx_pkg::OFF_FILE_DATA: avs_readdata <= {24'h000000, file_q};
        crsx_pkg::OFF_RESULT: avs_readdata <= {24'h000000, result_q};
        default: avs_readdata <= 32'h00000000;
      endcase
    end
  end
endmodule
`default_nettype wire

// >>> tb/crsx_exec_checker.sv
/* crsx_exec_checker: bus timing and sleep assertions.
   Assumes only the ports of crsx_exec; bound below. */
`timescale 1ns/1ps
`default_nettype none
module crsx_exec_checker (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // bus
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // sleep
  input wire logic ext_wake,
  input wire logic cpu_clock_run_q
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  // a fresh request gets exactly one wait
  a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest && $past(avs_waitrequest)
    |=> !avs_waitrequest) else $error("no accept after one wait");
  a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("accept longer than a cycle");
  a_read_upper: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h000000)
    else $error("upper read bits set");
  a_unmapped_zero: assert property (avs_read && !avs_waitrequest
    && !(avs_address inside {5'h00, 5'h04, 5'h08, 5'h0C, 5'h10}) |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  a_sleep_stop: assert property (avs_write && avs_waitrequest && avs_address == 5'h08
    && avs_byteenable[0] && avs_writedata[2:0] == 3'h6 |-> ##[1:2] !cpu_clock_run_q)
    else $error("sleep did not stop clock");
  // three quiet samples of the wake level keep the clock stopped
  a_stay_asleep: assert property (!cpu_clock_run_q && !ext_wake && !$past(ext_wake)
    && !$past(ext_wake, 2) |=> !cpu_clock_run_q) else $error("woke without cause");
  a_wake_bound: assert property ($rose(ext_wake) && !cpu_clock_run_q
    |-> ##[1:4] cpu_clock_run_q) else $error("wake too slow");
  a_stop_cause: assert property ($fell(cpu_clock_run_q)
    |-> $past(avs_write) && $past(avs_address) == 5'h08) else $error("clock stopped unasked");
  c_wake: cover property (!cpu_clock_run_q ##1 cpu_clock_run_q);
  c_read: cover property (avs_read && !avs_waitrequest);
  c_cmd: cover property (avs_write && !avs_waitrequest && avs_address == 5'h08);
endmodule
bind crsx_exec crsx_exec_checker chk_u (.clock, .rstn, .avs_address, .avs_read, .avs_write,
  .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .ext_wake, .cpu_clock_run_q);
`default_nettype wire

// >>> tb/tb.sv
/* tb: random instruction bench with a flag model.
   Assumes the checker binds itself to crsx_exec. */
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clock, rstn, avs_read, avs_write, ext_wake, avs_waitrequest, cpu_clock_run_q;
  logic [4:0] avs_address;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [7:0] a, f, k, r;
  logic [2:0] op, fl;
  logic ds, c, dc, z;
  int errors, n_compared, fi, ai, b, t;
  crsx_exec dut_u (.clock, .rstn, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .ext_wake, .cpu_clock_run_q);
  // 10 MHz clock
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  task automatic results();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  // idle edge first, so a release and a new request never share a time step
  task automatic bus(input logic wr, input logic [4:0] ad, input logic [31:0] d);
    int n;
    @(posedge clock);
    avs_address <= ad;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    // a request that never completes ends the run as a mismatch
    if (n >= 20) begin
      errors++;
      results();
    end
  endtask
  initial begin
    {rstn, avs_read, avs_write, ext_wake} = 4'h0;
    avs_address = 5'h00;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    void'($urandom(56));
    repeat (3) @(posedge clock);
    rstn <= 1'b1;
    bus(0, 5'h04, 0);
    chk("status", 0, q);
    // operands and flags random, flags seeded through the status register
    for (int i = 0; i < 80; i++) begin
      op = 3'($urandom_range(1, 5));
      ds = (op == 3'h4) ? 1'b0 : 1'($urandom_range(0, 1));
      a = 8'($urandom);
      f = 8'($urandom);
      k = 8'($urandom);
      fl = 3'($urandom);
      {z, dc, c} = fl;
      b = (op == 3'h3) ? int'(!c) : 0;
      fi = f;
      ai = a;
      t = fi - ai - b;
      case (op)
        3'h1: r = {c, f[7:1]};
        3'h4: r = a ^ k;
        3'h5: r = a ^ f;
        default: r = t[7:0];
      endcase
      if (op == 3'h1) c = f[0];
      if (op == 3'h2 || op == 3'h3) {c, dc} = {t >= 0, (fi % 16) - (ai % 16) - b >= 0};
      if (op != 3'h1) z = (r == 8'h00);
      bus(1, 5'h00, a);
      bus(1, 5'h0C, f);
      bus(1, 5'h04, fl);
      bus(1, 5'h08, {16'h0, k, 4'h0, ds, op});
      bus(0, 5'h00, 0);
      chk("acc", ds ? a : r, q);
      bus(0, 5'h0C, 0);
      chk("file", ds ? r : f, q);
      bus(0, 5'h10, 0);
      chk("result", r, q);
      bus(0, 5'h04, 0);
      chk("flags", {ds, 3'b000, z, dc, c}, q);
    end
    // masked write and unmapped read
    bus(1, 5'h00, 32'h3C);
    avs_byteenable <= 4'h0;
    bus(1, 5'h00, 32'hC3);
    avs_byteenable <= 4'hF;
    bus(0, 5'h14, 0);
    chk("unmapped", 0, q);
    // watchdog flag set by software so that sleep has something to clear
    bus(1, 5'h04, 32'h10);
    // wake level held low up to the sleep command
    bus(1, 5'h08, 32'(crsx_pkg::OP_SLEEP));
    chk("run", 0, cpu_clock_run_q);
    bus(1, 5'h08, 32'h0);
    bus(1, 5'h08, 32'h1);
    bus(0, 5'h00, 0);
    chk("acc", 32'h3C, q);
    bus(0, 5'h04, 0);
    chk("sleep", 32'h28, q & 32'h78);
    ext_wake <= 1'b1;
    for (int i = 0; i < 10 && cpu_clock_run_q !== 1'b1; i++) @(posedge clock);
    chk("run", 1, cpu_clock_run_q);
    bus(1, 5'h08, 32'h0);
    bus(0, 5'h00, 0);
    chk("acc", 32'h3C, q);
    bus(0, 5'h04, 0);
    chk("pdown", 32'h08, q & 32'h78);
    // mid-run reset is the only thing that clears power-down
    rstn <= 1'b0;
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    bus(0, 5'h04, 0);
    chk("status", 0, q);
    results();
  end
endmodule
`default_nettype wire
